// ### crt_cfg.svh
// crt_cfg.svh: register offsets, field positions, reset values and counts of the capture/reload timer
// assumes a byte-addressed avalon-mm slave with 32-bit data, one register per aligned word
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH

`define CRT_ADDR_W 5
`define CRT_OFS_CTRL 5'h00
`define CRT_OFS_CNT_LO 5'h04
`define CRT_OFS_CNT_HI 5'h08
`define CRT_OFS_HOLD_LO 5'h0c
`define CRT_OFS_HOLD_HI 5'h10
`define CRT_OFS_IRQ_STAT 5'h14
`define CRT_OFS_IRQ_CLR 5'h18
`define CRT_OFS_IRQ_EN 5'h1c

`define CRT_BIT_OVF 7
`define CRT_BIT_EXT 6
`define CRT_BIT_RXSEL 5
`define CRT_BIT_TXSEL 4
`define CRT_BIT_EDGE_EN 3
`define CRT_BIT_RUN 2
`define CRT_BIT_SRC 1
`define CRT_BIT_CAP 0

`define CRT_IRQ_BIT_OVF 0
`define CRT_IRQ_BIT_EXT 1

`define CRT_CTRL_RESET 8'h00
`define CRT_CNT_RESET 16'h0000
`define CRT_HOLD_RESET 16'h0000
`define CRT_IRQ_RESET 2'h0

`define CRT_PRESCALE 12

`endif

// ### crt_pkg.sv
// crt_pkg.sv: types shared by the capture/reload timer
// assumes crt_cfg.svh sits in the same folder
`default_nettype none

package crt_pkg;

  typedef enum logic [1:0] {
    CRT_OFF,
    CRT_AUTO_RELOAD,
    CRT_CAPTURE,
    CRT_BAUD
  } crt_mode_type;

  function automatic crt_mode_type crt_decode_mode(input logic run, input logic rx_sel,
                                                   input logic tx_sel, input logic cap);
    crt_mode_type m;
    m = CRT_OFF;
    if (!run) begin
      m = CRT_OFF;
    end else if (rx_sel || tx_sel) begin
      m = CRT_BAUD;
    end else if (cap) begin
      m = CRT_CAPTURE;
    end else begin
      m = CRT_AUTO_RELOAD;
    end
    return m;
  endfunction : crt_decode_mode

endpackage : crt_pkg

`default_nettype wire

// ### crt_timer.sv
// crt_timer.sv: 16-bit timer/event counter with capture, auto-reload and baud-clock modes
// assumes one clock, inputs synchronous enough to sample, avalon-mm master with waitrequest
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`include "crt_cfg.svh"
`default_nettype none

module crt_timer
  import crt_pkg::*;
#(
  parameter int unsigned PRESCALE = `CRT_PRESCALE
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register bus
  input wire logic [`CRT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // external pins
  input wire logic edge_input_pin,
  input wire logic count_input_pin,
  // serial port clocking
  input wire logic other_timer_ovf,
  output logic rx_baud_pulse,
  output logic tx_baud_pulse,
  // interrupt
  output logic irq
);
  import crt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] timer_control_reg;
  logic [15:0] count_reg;
  logic [15:0] hold_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_en_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [3:0] pre_reg;
  logic edge_s1_reg, edge_s2_reg, edge_prev_reg;
  logic cnt_s1_reg, cnt_s2_reg, cnt_prev_reg;
  logic rx_pulse_reg, tx_pulse_reg;

  logic overflow_flag, external_edge_flag, rx_clock_select, tx_clock_select;
  logic edge_input_enable, run_control, count_source_select, capture_not_reload;
  assign overflow_flag = timer_control_reg[`CRT_BIT_OVF];
  assign external_edge_flag = timer_control_reg[`CRT_BIT_EXT];
  assign rx_clock_select = timer_control_reg[`CRT_BIT_RXSEL];
  assign tx_clock_select = timer_control_reg[`CRT_BIT_TXSEL];
  assign edge_input_enable = timer_control_reg[`CRT_BIT_EDGE_EN];
  assign run_control = timer_control_reg[`CRT_BIT_RUN];
  assign count_source_select = timer_control_reg[`CRT_BIT_SRC];
  assign capture_not_reload = timer_control_reg[`CRT_BIT_CAP];

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle per access, taken at the second edge

  logic bus_req, bus_take, wr_take;
  logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_hold_lo, wr_hold_hi, wr_irq_clr, wr_irq_en;
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_reg;
  assign bus_take = bus_req && ack_reg;
  assign wr_take = avs_write && ack_reg;
  assign wr_ctrl = wr_take && (avs_address == `CRT_OFS_CTRL);
  assign wr_cnt_lo = wr_take && (avs_address == `CRT_OFS_CNT_LO);
  assign wr_cnt_hi = wr_take && (avs_address == `CRT_OFS_CNT_HI);
  assign wr_hold_lo = wr_take && (avs_address == `CRT_OFS_HOLD_LO);
  assign wr_hold_hi = wr_take && (avs_address == `CRT_OFS_HOLD_HI);
  assign wr_irq_clr = wr_take && (avs_address == `CRT_OFS_IRQ_CLR);
  assign wr_irq_en = wr_take && (avs_address == `CRT_OFS_IRQ_EN);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data is latched in the wait cycle so it stands at the taking edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        `CRT_OFS_CTRL: rdata_reg <= {24'h0, timer_control_reg};
        `CRT_OFS_CNT_LO: rdata_reg <= {24'h0, count_reg[7:0]};
        `CRT_OFS_CNT_HI: rdata_reg <= {24'h0, count_reg[15:8]};
        `CRT_OFS_HOLD_LO: rdata_reg <= {24'h0, hold_reg[7:0]};
        `CRT_OFS_HOLD_HI: rdata_reg <= {24'h0, hold_reg[15:8]};
        `CRT_OFS_IRQ_STAT: rdata_reg <= {30'h0, irq_stat_reg};
        `CRT_OFS_IRQ_EN: rdata_reg <= {30'h0, irq_en_reg};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers and falling edge detect

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_s1_reg <= 1'b1;
      edge_s2_reg <= 1'b1;
      edge_prev_reg <= 1'b1;
      cnt_s1_reg <= 1'b1;
      cnt_s2_reg <= 1'b1;
      cnt_prev_reg <= 1'b1;
    end else begin
      edge_s1_reg <= edge_input_pin;
      edge_s2_reg <= edge_s1_reg;
      edge_prev_reg <= edge_s2_reg;
      cnt_s1_reg <= count_input_pin;
      cnt_s2_reg <= cnt_s1_reg;
      cnt_prev_reg <= cnt_s2_reg;
    end
  end

  logic edge_fall, cnt_fall;
  assign edge_fall = edge_prev_reg && !edge_s2_reg;
  assign cnt_fall = cnt_prev_reg && !cnt_s2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode and count tick

  crt_mode_type mode;
  assign mode = crt_decode_mode(run_control, rx_clock_select, tx_clock_select,
                                capture_not_reload);

  // prescaler free-runs so the timer base does not depend on when run was set
  logic pre_wrap;
  assign pre_wrap = (pre_reg == 4'(PRESCALE - 1));
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_reg <= 4'h0;
    end else if (pre_wrap) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  logic tick, ovf_evt, edge_evt, cap_evt, reload_evt, baud_mode;
  assign tick = (mode != CRT_OFF) && (count_source_select ? cnt_fall : pre_wrap);
  assign ovf_evt = tick && (count_reg == 16'hffff);
  assign baud_mode = rx_clock_select || tx_clock_select;
  // edges only act while the counter is not feeding the serial port
  assign edge_evt = edge_input_enable && !baud_mode && edge_fall;
  assign cap_evt = edge_evt && capture_not_reload;
  assign reload_evt = (edge_evt && !capture_not_reload)
                      || (ovf_evt && (mode == CRT_AUTO_RELOAD || mode == CRT_BAUD));

  ////////////////////////////////////////////////////////////////////////////////
  // counter and hold registers; a software write wins over hardware here

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= `CRT_CNT_RESET;
    end else if (wr_cnt_lo) begin
      count_reg[7:0] <= avs_writedata[7:0];
    end else if (wr_cnt_hi) begin
      count_reg[15:8] <= avs_writedata[7:0];
    end else if (reload_evt) begin
      count_reg <= hold_reg;
    end else if (tick) begin
      count_reg <= count_reg + 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= `CRT_HOLD_RESET;
    end else if (wr_hold_lo) begin
      hold_reg[7:0] <= avs_writedata[7:0];
    end else if (wr_hold_hi) begin
      hold_reg[15:8] <= avs_writedata[7:0];
    end else if (cap_evt) begin
      hold_reg <= count_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register; flag sets win over a software clear in the same cycle

  logic set_ovf, set_ext;
  assign set_ovf = ovf_evt && !baud_mode;
  assign set_ext = edge_evt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_control_reg <= `CRT_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        timer_control_reg <= avs_writedata[7:0];
      end
      if (set_ovf) begin
        timer_control_reg[`CRT_BIT_OVF] <= 1'b1;
      end
      if (set_ext) begin
        timer_control_reg[`CRT_BIT_EXT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial clock routing

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_pulse_reg <= 1'b0;
      tx_pulse_reg <= 1'b0;
    end else begin
      rx_pulse_reg <= rx_clock_select ? ovf_evt : other_timer_ovf;
      tx_pulse_reg <= tx_clock_select ? ovf_evt : other_timer_ovf;
    end
  end
  assign rx_baud_pulse = rx_pulse_reg;
  assign tx_baud_pulse = tx_pulse_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= `CRT_IRQ_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_irq_clr && avs_writedata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (set_ovf) begin
        irq_stat_reg[`CRT_IRQ_BIT_OVF] <= 1'b1;
      end
      if (set_ext) begin
        irq_stat_reg[`CRT_IRQ_BIT_EXT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_reg <= `CRT_IRQ_RESET;
    end else if (wr_irq_en) begin
      irq_en_reg <= avs_writedata[1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_pin_high;
    edge_input_pin [*3];
  endsequence
  sequence s_pin_low;
    !edge_input_pin [*3];
  endsequence
  sequence s_cnt_high;
    count_input_pin [*3];
  endsequence
  sequence s_cnt_low;
    !count_input_pin [*3];
  endsequence

  // cycles since the last timer tick; saturates so a long stop cannot fake a short gap
  logic [3:0] tick_gap_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_gap_reg <= 4'hf;
    end else if (tick && !count_source_select) begin
      tick_gap_reg <= 4'h0;
    end else if (tick_gap_reg != 4'hf) begin
      tick_gap_reg <= tick_gap_reg + 4'h1;
    end
  end

  property p_baud_no_flag;
    baud_mode && !wr_ctrl && !overflow_flag |=> !overflow_flag;
  endproperty
  property p_capture_copy;
    cap_evt && !wr_hold_lo && !wr_hold_hi |=> hold_reg == $past(count_reg);
  endproperty
  property p_reload_load;
    reload_evt && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(hold_reg);
  endproperty
  property p_stop_holds;
    !run_control && !wr_cnt_lo && !wr_cnt_hi && !reload_evt |=> $stable(count_reg);
  endproperty
  property p_prescale_gap;
    tick && !count_source_select |-> tick_gap_reg >= 4'(PRESCALE - 1);
  endproperty
  property p_event_count;
    (s_cnt_high ##1 s_cnt_low) ##0 (count_source_select && run_control && !reload_evt)
    ##0 (!wr_cnt_lo && !wr_cnt_hi)
    |=> count_reg == $past(count_reg) + 16'h1;
  endproperty
  property p_count_step;
    tick && !reload_evt && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(count_reg) + 16'h1;
  endproperty
  property p_capture_wrap;
    ovf_evt && mode == CRT_CAPTURE && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == 16'h0000;
  endproperty
  property p_baud_reload;
    ovf_evt && mode == CRT_BAUD && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(hold_reg);
  endproperty
  property p_edge_reload;
    edge_evt && !capture_not_reload && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(hold_reg);
  endproperty
  property p_edge_ignored;
    edge_fall && (!edge_input_enable || baud_mode) && !wr_ctrl && !external_edge_flag
    |=> !external_edge_flag;
  endproperty
  property p_ctrl_write;
    wr_ctrl && !set_ovf && !set_ext |=> timer_control_reg == $past(avs_writedata[7:0]);
  endproperty

  a_fall_detect: assert property ((s_pin_high ##1 s_pin_low) |-> edge_fall)
    else $error("falling edge on edge pin not detected");
  a_event_count: assert property (p_event_count)
    else $error("count input fall did not advance counter");
  a_ovf_flag_set: assert property (ovf_evt && !baud_mode |=> overflow_flag)
    else $error("overflow did not set flag");
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("overflow flag set in baud mode");
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture did not copy count");
  a_edge_flag_set: assert property (edge_evt |=> external_edge_flag && irq_stat_reg[1])
    else $error("edge event did not set flag");
  a_reload_load: assert property (p_reload_load)
    else $error("reload did not load hold value");
  a_stop_holds: assert property (p_stop_holds)
    else $error("counter moved while stopped");
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("timer ticks closer than prescale");
  a_rx_route: assert property (rx_clock_select && ovf_evt |=> rx_baud_pulse)
    else $error("receive clock not from overflow");
  a_tx_route: assert property (!tx_clock_select && other_timer_ovf |=> tx_baud_pulse)
    else $error("transmit clock not from other timer");
  a_irq_level: assert property (irq_en_reg[1] && $past(set_ext) |-> irq)
    else $error("enabled edge flag did not raise irq");
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");
  a_capture_wrap: assert property (p_capture_wrap)
    else $error("capture overflow did not wrap to zero");
  a_baud_reload: assert property (p_baud_reload)
    else $error("baud overflow did not reload");
  a_edge_reload: assert property (p_edge_reload)
    else $error("enabled edge did not reload");
  a_edge_ignored: assert property (p_edge_ignored)
    else $error("blocked edge set the edge flag");
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");
  a_rx_other: assert property (!rx_clock_select && other_timer_ovf |=> rx_baud_pulse)
    else $error("receive clock not from other timer");
  a_tx_own: assert property (tx_clock_select && ovf_evt |=> tx_baud_pulse)
    else $error("transmit clock not from overflow");
  a_ovf_sticky: assert property (overflow_flag && !wr_ctrl |=> overflow_flag)
    else $error("overflow flag cleared by hardware");
  a_edge_sticky: assert property (external_edge_flag && !wr_ctrl |=> external_edge_flag)
    else $error("edge flag cleared by hardware");

endmodule : crt_timer

`default_nettype wire

// ### crt_partner.sv
// crt_partner.sv: edge source, count source, other timer and serial port seen from the timer
// assumes one clock; edge and count pins idle high as on a pulled-up port, driven right after rising edges
`default_nettype none

module crt_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial clock pulses from the timer
  input wire logic rx_baud_pulse,
  input wire logic tx_baud_pulse,
  // pins toward the timer
  output var logic edge_input_pin,
  output var logic count_input_pin,
  output var logic other_timer_ovf
);
  int rx_cnt;
  int tx_cnt;

  initial begin
    edge_input_pin = 1'b1;
    count_input_pin = 1'b1;
    other_timer_ovf = 1'b0;
    rx_cnt = 0;
    tx_cnt = 0;
  end

  // serial port side: count each clock pulse it receives
  always @(posedge sys_clk) begin
    if (rst_b === 1'b1 && rx_baud_pulse === 1'b1) rx_cnt++;
    if (rst_b === 1'b1 && tx_baud_pulse === 1'b1) tx_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // low and high phases last several samples so no fall is lost to the synchroniser
  task automatic fall_pin(input int which, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (which == 0) edge_input_pin <= 1'b0;
      else count_input_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      edge_input_pin <= 1'b1;
      count_input_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask : fall_pin

  task automatic other_pulse();
    @(posedge sys_clk);
    other_timer_ovf <= 1'b1;
    @(posedge sys_clk);
    other_timer_ovf <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : other_pulse
endmodule : crt_partner

`default_nettype wire

// ### crt_testbench.sv
// crt_testbench.sv: register-level tests of the capture/reload timer
// assumes crt_cfg.svh and crt_pkg in the same folder; prescaler shortened to 2
`include "crt_cfg.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic edge_input_pin, count_input_pin, other_timer_ovf;
  logic rx_baud_pulse, tx_baud_pulse, irq;
  int miscompares = 0;
  int n_compared = 0;
  int rx0, tx0;
  logic [31:0] q;

  always #5 sys_clk = ~sys_clk;

  crt_timer #(.PRESCALE(2)) crt_timer_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .edge_input_pin(edge_input_pin),
    .count_input_pin(count_input_pin), .other_timer_ovf(other_timer_ovf),
    .rx_baud_pulse(rx_baud_pulse), .tx_baud_pulse(tx_baud_pulse), .irq(irq));
  crt_partner crt_partner_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .rx_baud_pulse(rx_baud_pulse), .tx_baud_pulse(tx_baud_pulse),
    .edge_input_pin(edge_input_pin), .count_input_pin(count_input_pin),
    .other_timer_ovf(other_timer_ovf));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // waitrequest and read data are read at the rising edge, before that edge's updates land;
  // returns half a cycle later so callers see the state that the access left behind
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge sys_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input string name, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(name, {24'h0, e}, q);
  endtask : rd

  task automatic set16(input logic [4:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 5'h04, v[15:8]);
  endtask : set16

  task automatic rd16(input string name, input logic [4:0] lo, input logic [15:0] e);
    rd(name, lo, e[7:0]);
    rd(name, lo + 5'h04, e[15:8]);
  endtask : rd16

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 30 us
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd("ctrl", `CRT_OFS_CTRL, 8'h00);
    rd16("count", `CRT_OFS_CNT_LO, 16'h0000);
    rd16("hold", `CRT_OFS_HOLD_LO, 16'h0000);
    rd("unmapped", 5'h02, 8'h00);
    // capture mode, counting input falls across the wrap
    set16(`CRT_OFS_CNT_LO, 16'hfffd);
    wr(`CRT_OFS_CTRL, 8'h0f);
    crt_partner_inst.fall_pin(1, 3);
    rd16("count", `CRT_OFS_CNT_LO, 16'h0000);
    rd("ctrl", `CRT_OFS_CTRL, 8'h8f);
    crt_partner_inst.fall_pin(1, 1);
    crt_partner_inst.fall_pin(0, 1);
    rd16("hold", `CRT_OFS_HOLD_LO, 16'h0001);
    rd("ctrl", `CRT_OFS_CTRL, 8'hcf);
    // interrupt status, enable, clear
    rd("status", `CRT_OFS_IRQ_STAT, 8'h03);
    wr(`CRT_OFS_IRQ_EN, 8'h03);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`CRT_OFS_IRQ_CLR, 8'h01);
    wr(`CRT_OFS_IRQ_STAT, 8'h00);
    rd("status", `CRT_OFS_IRQ_STAT, 8'h02);
    rd("clear", `CRT_OFS_IRQ_CLR, 8'h00);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`CRT_OFS_IRQ_EN, 8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`CRT_OFS_IRQ_CLR, 8'h02);
    rd("status", `CRT_OFS_IRQ_STAT, 8'h00);
    wr(`CRT_OFS_CTRL, 8'h0f);
    rd("ctrl", `CRT_OFS_CTRL, 8'h0f);
    // edges ignored without enable, counting frozen while stopped
    wr(`CRT_OFS_CTRL, 8'h07);
    wr(`CRT_OFS_HOLD_LO, 8'h55);
    crt_partner_inst.fall_pin(0, 1);
    rd("hold lo", `CRT_OFS_HOLD_LO, 8'h55);
    rd("ctrl", `CRT_OFS_CTRL, 8'h07);
    wr(`CRT_OFS_CTRL, 8'h02);
    crt_partner_inst.fall_pin(1, 2);
    rd16("count", `CRT_OFS_CNT_LO, 16'h0001);
    // auto-reload on rollover and on enabled edge
    set16(`CRT_OFS_HOLD_LO, 16'h1234);
    set16(`CRT_OFS_CNT_LO, 16'hfffe);
    wr(`CRT_OFS_CTRL, 8'h0e);
    crt_partner_inst.fall_pin(1, 2);
    rd16("count", `CRT_OFS_CNT_LO, 16'h1234);
    rd("ctrl", `CRT_OFS_CTRL, 8'h8e);
    crt_partner_inst.fall_pin(1, 1);
    crt_partner_inst.fall_pin(0, 1);
    rd16("count", `CRT_OFS_CNT_LO, 16'h1234);
    rd("ctrl", `CRT_OFS_CTRL, 8'hce);
    // baud generation, receive path from this counter
    set16(`CRT_OFS_HOLD_LO, 16'hfffe);
    set16(`CRT_OFS_CNT_LO, 16'hfffe);
    wr(`CRT_OFS_CTRL, 8'h2e);
    rx0 = crt_partner_inst.rx_cnt;
    tx0 = crt_partner_inst.tx_cnt;
    crt_partner_inst.fall_pin(1, 2);
    crt_partner_inst.fall_pin(0, 1);
    chk("rx pulses", rx0 + 1, crt_partner_inst.rx_cnt);
    chk("tx pulses", tx0, crt_partner_inst.tx_cnt);
    rd16("count", `CRT_OFS_CNT_LO, 16'hfffe);
    rd("ctrl", `CRT_OFS_CTRL, 8'h2e);
    // transmit path from this counter, receive from the other timer
    wr(`CRT_OFS_CTRL, 8'h16);
    crt_partner_inst.other_pulse();
    chk("rx pulses", rx0 + 2, crt_partner_inst.rx_cnt);
    crt_partner_inst.fall_pin(1, 2);
    chk("tx pulses", tx0 + 1, crt_partner_inst.tx_cnt);
    chk("rx pulses", rx0 + 2, crt_partner_inst.rx_cnt);
    // timer mode: about one tick per two clocks over the run window
    wr(`CRT_OFS_CTRL, 8'h00);
    set16(`CRT_OFS_CNT_LO, 16'h0000);
    wr(`CRT_OFS_CTRL, 8'h04);
    repeat (40) @(posedge sys_clk);
    wr(`CRT_OFS_CTRL, 8'h00);
    bus(1'b0, `CRT_OFS_CNT_LO, 32'h0);
    chk("timer ticks in range", 32'h1, {31'h0, q >= 32'd16 && q <= 32'd28});
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
